// ==== rtl/rsef_filter.sv ====
// sync detection, disturbance filtering and transmit shaping with its apb register file
// Notes on behaviour
// - transmit control bit 0 set inverts the outgoing transmit signal.
// - transmit control bit 1 makes card conductance follow transmit-active instead of envelope.
// - receiver hunts for the 16-bit pattern in sync extension bits 31:16.
// - sync length field plus one gives the number of valid pattern bits.
// - falling-edge sync drops correlation limits and aligns bit grid to negative edge.
// - half-length last sync bit flag shortens the final sync bit by half.
// - sync type 0 treats all pattern bits as plain bit values.
// - sync type 1: each nibble is a data/collision pair; collided bits are don't-care.
// - sync type 2 resynchronises on the start bit of every byte.
// - polling reader settings load sets pattern b24d and length f.
// - first byte must equal the expected response code when code checking is on.
// - length byte above the maximum is disturbance when length checking is on.
// - length byte below the minimum is disturbance when length checking is on.
// - integrity error makes a response disturbance when its filter is enabled.
// - protocol error makes a response disturbance when its filter is enabled.
// - code check enable gates the code comparison; needs master enable.
// - length check enable gates both window comparisons; needs master enable.
// - master enable clear ignores all other disturbance settings.
//
// Chosen here: register access over APB.
`timescale 1ns/1ps
`default_nettype none
module rsef_filter (
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [rsef_pkg::APB_AW-1:0]   paddr,
  input  wire logic [31:0]                   pwdata,
  output logic      [31:0]                   prdata,
  output logic                               pready,
  output logic                               pslverr,
  input  wire logic                          tx_envelope,
  input  wire logic                          tx_active,
  output logic                               tx_out,
  output logic                               card_conductance_value,
  output logic                               grid_negedge,
  output logic                               corr_limits_off,
  output logic                               last_sync_half,
  input  wire logic                          rx_enable,
  input  wire logic                          rx_bit_valid,
  input  wire logic                          rx_bit,
  input  wire logic                          rx_frame_end,
  input  wire logic                          rx_integrity_err,
  input  wire logic                          rx_protocol_err,
  output logic                               sync_found,
  output logic      [7:0]                    rx_byte,
  output logic                               rx_byte_valid,
  output logic                               rx_done,
  output logic                               rx_discard
);
  import rsef_pkg::*;

  rsef_tx_ctrl_t   tx_ctrl;
  rsef_sync_ext_t  sync_ext;
  rsef_emd_ctrl_t  emd_ctrl;
  rsef_state_t     state;
  rsef_reason_t    last_reason;
  rsef_reason_t    next_reason;
  logic [15:0]     hist;
  logic [15:0]     next_hist;
  logic [15:0]     sync_mask;
  logic [15:0]     sync_exp;
  logic [15:0]     mask_bits;
  logic [15:0]     mask_nib;
  logic [15:0]     exp_nib;
  logic            sync_match;
  logic [3:0]      bit_cnt;
  logic [7:0]      byte_sr;
  logic [7:0]      next_byte;
  logic [1:0]      byte_idx;
  logic [7:0]      code_byte;
  logic [7:0]      len_byte;
  logic            got_code;
  logic            got_len;
  logic            stop_bad;
  logic            byte_done;
  logic            framed;
  logic            partial;
  logic            discard_now;
  logic            last_accept;
  logic            last_discard;
  logic [7:0]      acc_cnt;
  logic [7:0]      disc_cnt;
  logic [9:0]      word;
  logic            mapped;
  logic            wr_en;
  logic            load_jis;
  logic [31:0]     next_rdata;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  ////////////////////////////////////////////////////////////////////////////
  // apb slave: no wait states; read data and pready come from flip-flops loaded in the setup cycle
  assign word     = paddr[APB_AW-1:2];
  assign mapped   = (word == IDX_TX_CTRL) || (word == IDX_SYNC_EXT) || (word == IDX_EMD_CTRL)
                    || (word == IDX_STATUS) || (word == IDX_LOAD_CMD);
  assign wr_en    = psel && penable && pready && pwrite && mapped;
  assign load_jis = wr_en && (word == IDX_LOAD_CMD) && pwdata[LOAD_JIS_BIT];

  always_comb begin
    next_rdata = 32'h0000_0000;
    case (word)
      IDX_TX_CTRL:  next_rdata = tx_ctrl;
      IDX_SYNC_EXT: next_rdata = sync_ext;
      IDX_EMD_CTRL: next_rdata = emd_ctrl;
      IDX_STATUS:   next_rdata = {disc_cnt, acc_cnt, 3'h0, last_reason, 3'h0, last_discard, last_accept,
                                  1'b0, state};
      default:      next_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      prdata  <= (psel && !penable && !pwrite) ? next_rdata : 32'h0000_0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_ctrl  <= TX_CTRL_RST;
      sync_ext <= SYNC_EXT_RST;
      emd_ctrl <= EMD_CTRL_RST;
    end else begin
      if (wr_en && word == IDX_TX_CTRL) begin
        tx_ctrl <= pwdata;
      end
      if (wr_en && word == IDX_SYNC_EXT) begin
        sync_ext <= pwdata;
      end
      if (load_jis) begin
        // a load always restores the default pattern; custom ones must be rewritten after it
        sync_ext.pattern             <= JIS_SYNC_PATTERN;
        sync_ext.sync_pattern_length <= JIS_SYNC_PATTERN_LENGTH;
      end
      if (wr_en && word == IDX_EMD_CTRL) begin
        emd_ctrl <= pwdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transmit shaping and front-end steering
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_out                 <= 1'b0;
      card_conductance_value <= 1'b0;
      grid_negedge           <= 1'b0;
      corr_limits_off        <= 1'b0;
      last_sync_half         <= 1'b0;
    end else begin
      tx_out                 <= tx_envelope ^ tx_ctrl.invert;
      card_conductance_value <= tx_ctrl.card_conductance_follow_txact ? tx_active : tx_envelope;
      grid_negedge           <= sync_ext.negedge_grid;
      corr_limits_off        <= sync_ext.negedge_grid;
      last_sync_half         <= sync_ext.last_half;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sync pattern: per-bit mask and expected value for both pattern readings
  for (genvar i = 0; i < 16; i++) begin : g_sync_bit
    assign mask_bits[i] = 4'(i) <= sync_ext.sync_pattern_length;
    if (i < 4) begin : g_nib
      assign exp_nib[i]  = sync_ext.pattern[4*i+1];
      assign mask_nib[i] = mask_bits[i] && !sync_ext.pattern[4*i];
    end else begin : g_nonib
      assign exp_nib[i]  = 1'b0;
      assign mask_nib[i] = 1'b0;
    end
  end

  assign sync_mask  = (sync_ext.sync_type == SYNC_NIBBLES) ? mask_nib : mask_bits;
  assign sync_exp   = (sync_ext.sync_type == SYNC_NIBBLES) ? exp_nib : sync_ext.pattern;
  assign next_hist  = {hist[14:0], rx_bit};
  // bytewise mode has no preamble: any start bit opens the frame
  assign sync_match = (sync_ext.sync_type == SYNC_BYTEWISE) ? !rx_bit
                      : (((next_hist ^ sync_exp) & sync_mask) == 16'h0000);

  ////////////////////////////////////////////////////////////////////////////
  // receive state machine
  assign framed    = sync_ext.sync_type == SYNC_BYTEWISE;
  assign next_byte = {byte_sr[6:0], rx_bit};
  assign byte_done = rx_bit_valid && (bit_cnt == (framed ? LAST_DATA_BIT_FRAMED : LAST_DATA_BIT_PLAIN));
  assign partial   = framed ? (bit_cnt != 4'h0) : (bit_cnt != 4'h0);

  always_comb begin
    next_reason           = '0;
    next_reason.code      = emd_ctrl.response_code_check_en
                            && (!got_code || code_byte != emd_ctrl.expected_response_code);
    next_reason.len_max   = emd_ctrl.length_window_check_en && got_len
                            && (len_byte > emd_ctrl.response_length_max);
    next_reason.len_min   = emd_ctrl.length_window_check_en
                            && (!got_len || len_byte < emd_ctrl.response_length_min);
    next_reason.integrity = emd_ctrl.integrity_error_filter_en && rx_integrity_err;
    next_reason.protocol  = emd_ctrl.protocol_error_filter_en
                            && (rx_protocol_err || partial || stop_bad);
    if (!emd_ctrl.disturbance_filter_en) begin
      next_reason = '0;
    end
  end
  assign discard_now = |next_reason;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
    end else if (!rx_enable) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: state <= ST_HUNT;
        ST_HUNT: begin
          if (rx_bit_valid && sync_match) begin
            state <= ST_DATA;
          end
        end
        ST_DATA: begin
          if (rx_frame_end) begin
            state <= ST_DONE;
          end
        end
        ST_DONE: state <= ST_HUNT;
        default: state <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hist       <= 16'h0000;
      sync_found <= 1'b0;
    end else begin
      sync_found <= 1'b0;
      if (state != ST_HUNT) begin
        hist <= 16'h0000;
      end else if (rx_bit_valid) begin
        hist       <= next_hist;
        sync_found <= rx_enable && sync_match;
      end
    end
  end

  // byte assembly; framed mode counts start, eight data bits and stop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bit_cnt       <= 4'h0;
      byte_sr       <= 8'h00;
      byte_idx      <= 2'h0;
      code_byte     <= 8'h00;
      len_byte      <= 8'h00;
      got_code      <= 1'b0;
      got_len       <= 1'b0;
      stop_bad      <= 1'b0;
      rx_byte       <= 8'h00;
      rx_byte_valid <= 1'b0;
    end else begin
      rx_byte_valid <= 1'b0;
      if (state != ST_DATA) begin
        bit_cnt  <= (framed && state == ST_HUNT && rx_bit_valid && !rx_bit) ? 4'h1 : 4'h0;
        byte_idx <= 2'h0;
        got_code <= 1'b0;
        got_len  <= 1'b0;
        stop_bad <= 1'b0;
      end else if (!rx_frame_end && rx_bit_valid) begin
        if (framed && bit_cnt == 4'h0) begin
          bit_cnt <= rx_bit ? 4'h0 : 4'h1;
        end else if (framed && bit_cnt == STOP_BIT_FRAMED) begin
          bit_cnt  <= 4'h0;
          stop_bad <= stop_bad || !rx_bit;
        end else begin
          byte_sr <= next_byte;
          bit_cnt <= (byte_done && !framed) ? 4'h0 : bit_cnt + 4'h1;
        end
        if (byte_done) begin
          rx_byte       <= next_byte;
          rx_byte_valid <= 1'b1;
          if (byte_idx != 2'h3) begin
            byte_idx <= byte_idx + 2'h1;
          end
          if (byte_idx == RC_BYTE_POS) begin
            code_byte <= next_byte;
            got_code  <= 1'b1;
          end
          if (byte_idx == LEN_BYTE_POS) begin
            len_byte <= next_byte;
            got_len  <= 1'b1;
          end
        end
      end
    end
  end

  // verdict: disturbance never raises done, only the discard marker
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_done      <= 1'b0;
      rx_discard   <= 1'b0;
      last_reason  <= '0;
      last_accept  <= 1'b0;
      last_discard <= 1'b0;
      acc_cnt      <= 8'h00;
      disc_cnt     <= 8'h00;
    end else begin
      rx_done    <= 1'b0;
      rx_discard <= 1'b0;
      if (rx_enable && state == ST_DATA && rx_frame_end) begin
        rx_done      <= !discard_now;
        rx_discard   <= discard_now;
        last_reason  <= next_reason;
        last_accept  <= !discard_now;
        last_discard <= discard_now;
        // counters wrap; software reads differences
        if (discard_now) begin
          disc_cnt <= disc_cnt + 8'h01;
        end else begin
          acc_cnt <= acc_cnt + 8'h01;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  a_tx_invert_path: assert property (tx_out == ($past(tx_envelope) ^ $past(tx_ctrl.invert)))
    else $error("transmit output not envelope xor invert");
  a_conductance_src: assert property (card_conductance_value ==
      ($past(tx_ctrl.card_conductance_follow_txact) ? $past(tx_active) : $past(tx_envelope)))
    else $error("card conductance source wrong");
  a_sync_full_match: assert property (sync_found && $past(sync_ext.sync_type) == SYNC_BITS
      && $past(sync_ext.sync_pattern_length) == 4'hf |-> $past(next_hist) == $past(sync_ext.pattern))
    else $error("sync reported without full pattern");
  a_one_bit_sync: assert property (rx_enable && state == ST_HUNT && rx_bit_valid
      && sync_ext.sync_type == SYNC_BITS && sync_ext.sync_pattern_length == 4'h0
      && rx_bit == sync_ext.pattern[0] |=> sync_found && state == ST_DATA)
    else $error("single bit sync not taken");
  a_grid_steer: assert property (grid_negedge == corr_limits_off && last_sync_half == $past(sync_ext.last_half))
    else $error("grid steering outputs disagree");
  a_all_collided: assert property (rx_enable && state == ST_HUNT && rx_bit_valid
      && sync_ext.sync_type == SYNC_NIBBLES && sync_ext.pattern[0] && sync_ext.pattern[4]
      && sync_ext.pattern[8] && sync_ext.pattern[12] |=> sync_found)
    else $error("collided nibbles not ignored");
  a_bytewise_start: assert property (rx_enable && state == ST_HUNT && rx_bit_valid && !rx_bit
      && sync_ext.sync_type == SYNC_BYTEWISE |=> state == ST_DATA ##0 bit_cnt == 4'h1)
    else $error("start bit did not open frame");
  a_load_defaults: assert property (load_jis |=> sync_ext.pattern == JIS_SYNC_PATTERN
      && sync_ext.sync_pattern_length == JIS_SYNC_PATTERN_LENGTH)
    else $error("settings load did not restore sync");
  a_code_reject: assert property (rx_enable && state == ST_DATA && rx_frame_end
      && emd_ctrl.disturbance_filter_en && emd_ctrl.response_code_check_en && got_code
      && code_byte != emd_ctrl.expected_response_code |=> rx_discard && !rx_done)
    else $error("wrong response code accepted");
  a_len_window: assert property (rx_enable && state == ST_DATA && rx_frame_end
      && emd_ctrl.disturbance_filter_en && emd_ctrl.length_window_check_en && got_len
      && (len_byte > emd_ctrl.response_length_max || len_byte < emd_ctrl.response_length_min)
      |=> rx_discard)
    else $error("length outside window accepted");
  a_err_filters: assert property (rx_enable && state == ST_DATA && rx_frame_end && emd_ctrl.disturbance_filter_en
      && ((emd_ctrl.integrity_error_filter_en && rx_integrity_err)
      || (emd_ctrl.protocol_error_filter_en && rx_protocol_err)) |=> rx_discard)
    else $error("errored response accepted");
  a_master_off: assert property (rx_discard |-> $past(emd_ctrl.disturbance_filter_en))
    else $error("discard while filter disabled");
  a_discard_relisten: assert property (rx_discard && rx_enable |=> state == ST_HUNT && !rx_done)
    else $error("receiver did not resume after discard");

  c_sync_then_done: cover property (sync_found ##[1:1000] rx_done);
  c_sync_then_discard: cover property (sync_found ##[1:1000] rx_discard);
  c_bytewise_byte: cover property (sync_ext.sync_type == SYNC_BYTEWISE && rx_byte_valid);
  c_load_cmd: cover property (load_jis);

endmodule
`default_nettype wire

// ==== rtl/rsef_pkg.sv ====
// package: register map, field layouts, constants and carriers for the sync and disturbance filter
package rsef_pkg;

  localparam int unsigned APB_AW = 12;

  // printed offsets are word indices; byte address is four times the index
  localparam logic [9:0] IDX_TX_CTRL   = 10'h036;
  localparam logic [9:0] IDX_SYNC_EXT  = 10'h039;
  localparam logic [9:0] IDX_EMD_CTRL  = 10'h043;
  localparam logic [9:0] IDX_STATUS    = 10'h044;
  localparam logic [9:0] IDX_LOAD_CMD  = 10'h045;

  localparam logic [31:0] TX_CTRL_RST  = 32'h0000_0000;
  localparam logic [31:0] SYNC_EXT_RST = 32'h0000_0000;
  localparam logic [31:0] EMD_CTRL_RST = 32'h0000_0000;

  // load command bit selecting the 212/424 kbit/s polling reader settings
  localparam int unsigned LOAD_JIS_BIT = 0;
  localparam logic [15:0] JIS_SYNC_PATTERN = 16'hb24d;
  localparam logic [3:0]  JIS_SYNC_PATTERN_LENGTH     = 4'hf;

  // position of the response code and length byte within a response
  localparam logic [1:0] RC_BYTE_POS  = 2'h0;
  localparam logic [1:0] LEN_BYTE_POS = 2'h1;

  // bit counter figures for plain and start/stop framed bytes
  localparam logic [3:0] LAST_DATA_BIT_PLAIN  = 4'h7;
  localparam logic [3:0] LAST_DATA_BIT_FRAMED = 4'h8;
  localparam logic [3:0] STOP_BIT_FRAMED      = 4'h9;

  typedef enum logic [1:0] {
    SYNC_BITS    = 2'h0,
    SYNC_NIBBLES = 2'h1,
    SYNC_BYTEWISE = 2'h2
  } rsef_sync_type_t;

  typedef struct packed {
    logic [29:0] rfu;
    logic        card_conductance_follow_txact;
    logic        invert;
  } rsef_tx_ctrl_t;

  typedef struct packed {
    logic [15:0] pattern;
    logic [3:0]  sync_pattern_length;
    logic        negedge_grid;
    logic        last_half;
    logic [1:0]  sync_type;
    logic [7:0]  rfu;
  } rsef_sync_ext_t;

  typedef struct packed {
    logic [7:0] expected_response_code;
    logic [7:0] response_length_max;
    logic [7:0] response_length_min;
    logic [2:0] rfu;
    logic       integrity_error_filter_en;
    logic       protocol_error_filter_en;
    logic       response_code_check_en;
    logic       length_window_check_en;
    logic       disturbance_filter_en;
  } rsef_emd_ctrl_t;

  typedef struct packed {
    logic code;
    logic len_max;
    logic len_min;
    logic integrity;
    logic protocol;
  } rsef_reason_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_HUNT = 2'b01,
    ST_DATA = 2'b11,
    ST_DONE = 2'b10
  } rsef_state_t;

endpackage

// ==== test/rsef_card_model.sv ====
// transponder model: sends sync bits, response bytes and the frame end
`timescale 1ns/1ps
`default_nettype none
module rsef_card_model (
  input  wire logic pclk,
  output logic      rx_bit_valid,
  output logic      rx_bit,
  output logic      rx_frame_end,
  output logic      rx_integrity_err,
  output logic      rx_protocol_err
);
  initial begin
    rx_bit_valid = 1'b0;
    rx_bit = 1'b1;
    rx_frame_end = 1'b0;
    rx_integrity_err = 1'b0;
    rx_protocol_err = 1'b0;
  end
  ////////////////////////////////////////
  task automatic put_bit(input logic b);
    @(posedge pclk);
    rx_bit_valid <= 1'b1;
    rx_bit <= b;
    @(posedge pclk);
    rx_bit_valid <= 1'b0;
    // no held value between bits: the line flips to the complement, so a late sample reads the wrong bit
    rx_bit <= ~b;
  endtask
  // pattern bit len goes first, bit 0 last; then two bytes msb first
  // fr wraps each byte in a start 0 and stop 1; len below zero sends no pattern
  task automatic send(input logic [15:0] p, input int len, input logic [7:0] b0, input logic [7:0] b1,
                      input logic ie, input logic pe, input logic fr);
    for (int i = len; i >= 0; i--) put_bit(p[i]);
    for (int j = 0; j < 2; j++) begin
      if (fr) put_bit(1'b0);
      for (int i = 7; i >= 0; i--) put_bit(j ? b1[i] : b0[i]);
      if (fr) put_bit(1'b1);
    end
    @(posedge pclk);
    rx_frame_end <= 1'b1;
    rx_integrity_err <= ie;
    rx_protocol_err <= pe;
    @(posedge pclk);
    rx_frame_end <= 1'b0;
    rx_integrity_err <= ~ie;
    rx_protocol_err <= ~pe;
    repeat (3) @(posedge pclk);
  endtask
endmodule
`default_nettype wire

// ==== test/rsef_filter_tb_top.sv ====
// self-checking bench: apb registers, transmit shaping, sync hunt and response filtering
`timescale 1ns/1ps
`default_nettype none
module rsef_filter_tb_top;
  import rsef_pkg::*;
  logic              pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic [APB_AW-1:0] paddr;
  logic [31:0]       pwdata, prdata, q, v, c;
  logic              tx_envelope, tx_active, tx_out, card_conductance_value;
  logic              grid_negedge, corr_limits_off, last_sync_half, rx_enable;
  logic              rx_bit_valid, rx_bit, rx_frame_end, rx_integrity_err, rx_protocol_err;
  logic              sync_found, rx_byte_valid, rx_done, rx_discard, ie, pe, d, fr;
  logic [7:0]        rx_byte, rc, ln;
  logic [9:0]        regs [3] = '{IDX_TX_CTRL, IDX_SYNC_EXT, IDX_EMD_CTRL};
  int                miscompares, total_checks, syncs;
  logic              exp_q [$];
  logic [7:0]        byte_q [$];

  rsef_filter dut (.*);
  rsef_card_model card (.*);

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [9:0] idx, input logic [31:0] wd);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    // a slave that never answers counts against the run
    if (pready !== 1'b1) miscompares++;
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic disc(input logic [31:0] k, input logic [7:0] r, input logic [7:0] l,
                                input logic i, input logic p);
    return k[0] & ((k[2] & (r != k[31:24])) | (k[1] & (l > k[23:16] | l < k[15:8])) | (k[4] & i) | (k[3] & p));
  endfunction

  task automatic frame(input logic [15:0] p, input int len, input int hit);
    int s;
    s = syncs;
    if (hit != 0) begin
      byte_q.push_back(rc);
      byte_q.push_back(ln);
      exp_q.push_back(disc(c, rc, ln, ie, pe));
    end
    card.send(p, len, rc, ln, ie, pe, fr);
    chk(syncs, s + hit);
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////
  always @(posedge pclk) begin
    if (sync_found === 1'b1) syncs++;
    if (rx_byte_valid === 1'b1) chk(rx_byte, byte_q.size() ? byte_q.pop_front() : 8'hxx);
    if (rx_done === 1'b1 || rx_discard === 1'b1) begin
      d = exp_q.size() ? exp_q.pop_front() : 1'bx;
      chk({rx_done, rx_discard}, {~d, d});
    end
  end

  initial begin
    #200_000;
    miscompares++;
    summarize();
  end

  initial begin
    {psel, penable, pwrite, paddr, pwdata, tx_envelope, tx_active} = '0;
    rx_enable = 1'b1;
    fr = 1'b0;
    presetn = 1'b0;
    void'($urandom(32'hbb98));
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    foreach (regs[i]) begin
      apb(0, regs[i], 0);
      chk(q, 0);
      v = $urandom;
      apb(1, regs[i], v);
      apb(0, regs[i], 0);
      chk(q, v);
    end
    apb(1, 10'h3ff, v);
    chk(e, 1);
    apb(0, 10'h3ff, 0);
    chk(q, 0);
    $display("test registers done");
    for (int k = 0; k < 4; k++) begin
      apb(1, IDX_TX_CTRL, 32'(k));
      repeat (6) begin
        @(posedge pclk);
        tx_envelope <= 1'($urandom);
        tx_active <= 1'($urandom);
        @(posedge pclk);
        #1;
        chk(tx_out, tx_envelope ^ k[0]);
        chk(card_conductance_value, k[1] ? tx_active : tx_envelope);
      end
    end
    for (int k = 3; k >= 0; k--) begin
      apb(1, IDX_SYNC_EXT, 32'(k) << 10);
      @(posedge pclk);
      #1;
      chk({grid_negedge, corr_limits_off, last_sync_half}, {k[1], k[1], k[0]});
    end
    $display("test transmit and grid done");
    apb(1, IDX_LOAD_CMD, 32'h1);
    apb(0, IDX_SYNC_EXT, 0);
    chk(q, 32'hb24d_f000);
    for (int i = 0; i < 20; i++) begin
      c = i ? {24'h07_1004, 3'b000, 5'($urandom)} : 32'h00ff_0019;
      rc = $urandom_range(1) ? 8'h07 : 8'h08;
      ln = 8'($urandom_range(17, 3));
      ie = 1'($urandom);
      pe = 1'($urandom);
      apb(1, IDX_EMD_CTRL, c);
      frame(16'hb24d, 15, 1);
    end
    $display("test filtering done");
    rc = 8'h11;
    ln = 8'h22;
    frame(16'h0000, 15, 0);
    apb(1, IDX_SYNC_EXT, 32'h5aa5_7000);
    frame(16'h5aa5, 7, 1);
    apb(1, IDX_LOAD_CMD, 32'h1);
    apb(0, IDX_SYNC_EXT, 0);
    chk(q, 32'hb24d_f000);
    frame(16'hb24d, 15, 1);
    // nibble pairs: bit0 data 1, bit1 collided, so a single 1 must sync
    apb(1, IDX_SYNC_EXT, 32'h0012_1100);
    frame(16'h0001, 0, 1);
    // bytewise framing: the start bit of the first byte opens the frame
    fr = 1'b1;
    apb(1, IDX_SYNC_EXT, 32'h0000_0200);
    frame(16'h0000, -1, 1);
    chk(exp_q.size(), 0);
    chk(byte_q.size(), 0);
    $display("test sync length done");
    summarize();
  end
endmodule
`default_nettype wire
